// ---- hw/cnt_pkg.sv ----
package cnt_pkg;
  localparam int          VW           = 20;
  localparam logic [19:0] FULL_SCALE   = 20'hf423f;
  localparam logic [19:0] ALARM_MAX    = 20'h0270f;
  localparam logic [9:0]  ACT_UNIT_M1  = 10'h3e7;
  localparam int          NSET         = 10;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_SV1      = 8'h04;
  localparam logic [7:0]  OFS_SV2      = 8'h08;
  localparam logic [7:0]  OFS_FC       = 8'h0c;
  localparam logic [7:0]  OFS_BSV      = 8'h10;
  localparam logic [7:0]  OFS_SVLIM    = 8'h14;
  localparam logic [7:0]  OFS_FCLIM    = 8'h18;
  localparam logic [7:0]  OFS_BLIM     = 8'h1c;
  localparam logic [7:0]  OFS_THR1     = 8'h20;
  localparam logic [7:0]  OFS_THR2     = 8'h24;
  localparam logic [7:0]  OFS_RUN      = 8'h28;
  localparam logic [7:0]  OFS_STAT     = 8'h2c;
  localparam logic [7:0]  OFS_PV1      = 8'h30;
  localparam logic [7:0]  OFS_PV2      = 8'h34;
  localparam logic [7:0]  OFS_BATCH    = 8'h38;
  localparam logic [7:0]  OFS_DUAL     = 8'h3c;
  localparam logic [7:0]  OFS_MON1     = 8'h40;
  localparam logic [7:0]  OFS_MON2     = 8'h44;
  localparam int          CF_MODE      = 0;
  localparam int          CF_FCSEL     = 3;
  localparam int          CF_SWAP      = 4;
  localparam int          CF_SUB       = 5;
  localparam int          CF_FAST      = 6;
  localparam int          CF_RFAST     = 7;
  localparam int          CF_COL       = 8;
  localparam logic [31:0] CTRL_RST     = 32'h0;
  localparam logic [31:0] SV_RST       = 32'h0;
  localparam logic [31:0] LIM_RST      = {12'h0, FULL_SCALE};
  localparam int          CLK_NS       = 4;
  localparam int          MIN_W_SLOW_NS = 16_700_000;
  localparam int          MIN_W_FAST_NS = 100_000;
  localparam int          RST_W_SLOW_NS = 20_000_000;
  localparam int          RST_W_FAST_NS = 1_000_000;
  localparam int          CNT_SLOW_CYC = MIN_W_SLOW_NS / 2 / CLK_NS;
  localparam int          CNT_FAST_CYC = MIN_W_FAST_NS / 2 / CLK_NS;
  localparam int          RST_SLOW_CYC = RST_W_SLOW_NS / CLK_NS;
  localparam int          RST_FAST_CYC = RST_W_FAST_NS / CLK_NS;
  localparam int          FILT_W       = 23;
  typedef enum logic [2:0] {CFG_SINGLE, CFG_TWO_STAGE, CFG_BATCH, CFG_DUAL, CFG_TWIN} cfg_e;
  typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_ORANGE} colour_e;
  typedef enum logic [3:0] {SEL_RED, SEL_GREEN, SEL_ORANGE, SEL_R_G, SEL_G_R,
                            SEL_R_O, SEL_O_R, SEL_G_O, SEL_O_G} colour_sel_e;
  typedef struct packed {
    logic count_input_one;
    logic count_input_two;
    logic reset_input_one;
    logic reset_input_two;
  } sensor_in_s;
  typedef struct packed {
    logic    control_output_one;
    logic    control_output_two;
    colour_e colour;
    logic    alarm;
  } panel_out_s;
endpackage : cnt_pkg

// ---- hw/preset_counter_compare_logic.sv ----
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module preset_counter_compare_logic #(
  parameter int CNT_SLOW = cnt_pkg::CNT_SLOW_CYC,
  parameter int CNT_FAST = cnt_pkg::CNT_FAST_CYC,
  parameter int RST_SLOW = cnt_pkg::RST_SLOW_CYC,
  parameter int RST_FAST = cnt_pkg::RST_FAST_CYC
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire cnt_pkg::sensor_in_s sensor_in,
  output cnt_pkg::panel_out_s      panel_out
);
  import cnt_pkg::*;

  logic [31:0]     shadow_q [NSET];
  logic [31:0]     act_q    [NSET];
  logic            aw_q;
  logic [7:0]      aa_q;
  logic [31:0]     rdata_q;
  logic            run_q;
  logic            run_prev_q;
  logic            started_q;
  logic [VW-1:0]   pv1_q;
  logic [VW-1:0]   pv2_q;
  logic [VW-1:0]   batch_q;
  logic            bout_q;
  logic            control_output_one_q;
  logic            control_output_two_q;
  logic            control_output_one_d;
  logic            control_output_two_d;
  logic [1:0]      act_d;
  logic [1:0]      act_qv;
  logic [1:0]      alarm_w;
  logic [VW-1:0]   mon [2];
  logic [9:0]      sub [2];
  logic [3:0]      filt;
  logic [3:0]      edge_w;
  panel_out_s      pan_q;
  colour_e         colour_d;
  logic [31:0]     rd_d;

  function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction : clampv

  // ahb-lite slave, zero wait states; read data prepared in the address phase
  wire        take     = hsel & hready & htrans[1];
  wire [3:0]  widx     = aa_q[5:2];
  wire        wmapped  = (aa_q[1:0] == 2'b00) && (aa_q <= OFS_THR2);
  wire        run_wr   = aw_q && (aa_q == OFS_RUN);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // set value, forecast and batch writes limited by the shadow limits software sees right now; limits and thresholds by fixed ranges
  logic [31:0] wval;
  always_comb
  begin
    wval = hwdata;
    case (aa_q)
      OFS_SV1, OFS_SV2: wval = clampv(hwdata, 32'h0, shadow_q[OFS_SVLIM[5:2]]);
      OFS_FC:           wval = clampv(hwdata, 32'h0, shadow_q[OFS_FCLIM[5:2]]);
      OFS_BSV:          wval = clampv(hwdata, 32'h0, shadow_q[OFS_BLIM[5:2]]);
      OFS_SVLIM, OFS_FCLIM, OFS_BLIM:
        wval = clampv(hwdata, 32'h1, LIM_RST);
      OFS_THR1, OFS_THR2: wval = clampv(hwdata, 32'h0, {12'h0, ALARM_MAX});
      default:          wval = hwdata;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aw_q    <= 1'b0;
      aa_q    <= 8'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      aw_q    <= take & hwrite;
      aa_q    <= haddr[7:0];
      rdata_q <= (take & ~hwrite) ? rd_d : rdata_q;
    end
  end

  // settings are edited in the shadow copy and only take effect on run entry
  wire apply   = run_q & ~run_prev_q;
  wire changed = (shadow_q != act_q);
  wire clear   = apply & changed;

  generate
    for (genvar i = 0; i < NSET; i++)
    begin : g_set
      localparam logic [31:0] RV = (i == 0) ? CTRL_RST :
                                   (i >= 5 && i <= 7) ? LIM_RST : SV_RST;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          shadow_q[i] <= RV;
          act_q[i]    <= RV;
        end
        else
        begin
          if (aw_q && wmapped && widx == 4'(i))
            shadow_q[i] <= wval;
          if (apply)
            act_q[i] <= shadow_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q      <= 1'b0;
      run_prev_q <= 1'b0;
      started_q  <= 1'b0;
    end
    else
    begin
      run_q      <= run_wr ? hwdata[0] : run_q;
      run_prev_q <= run_q;
      started_q  <= started_q | apply;
    end
  end

  // active settings
  wire [31:0]     ctrl   = act_q[0];
  wire cfg_e      cfg    = cfg_e'(ctrl[CF_MODE +: 3]);
  wire            fcsel  = ctrl[CF_FCSEL];
  wire            swap   = ctrl[CF_SWAP];
  wire            dsub   = ctrl[CF_SUB];
  wire colour_sel_e csel = colour_sel_e'(ctrl[CF_COL +: 4]);
  wire [VW-1:0]   sv1    = act_q[OFS_SV1[5:2]][VW-1:0];
  wire [VW-1:0]   sv2    = act_q[OFS_SV2[5:2]][VW-1:0];
  wire [VW-1:0]   fcv    = act_q[OFS_FC[5:2]][VW-1:0];
  wire [VW-1:0]   bsv    = act_q[OFS_BSV[5:2]][VW-1:0];
  wire [VW-1:0]   thr [2];
  assign thr[0] = act_q[OFS_THR1[5:2]][VW-1:0];
  assign thr[1] = act_q[OFS_THR2[5:2]][VW-1:0];

  // sync then debounce filter; the count filter is half the shortest legal width, the reset filter the full reset width,
  // so a pulse meeting the sensor timing is seen once and chatter is not
  wire [3:0] raw = {sensor_in.count_input_one, sensor_in.count_input_two,
                    sensor_in.reset_input_one, sensor_in.reset_input_two};
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_in
      logic              s1_q;
      logic              s2_q;
      logic              f_q;
      logic              fp_q;
      logic [FILT_W-1:0] c_q;
      wire  [FILT_W-1:0] lim = (i >= 2) ?
        (ctrl[CF_FAST] ? FILT_W'(CNT_FAST) : FILT_W'(CNT_SLOW)) :
        (ctrl[CF_RFAST] ? FILT_W'(RST_FAST) : FILT_W'(RST_SLOW));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          f_q  <= 1'b0;
          fp_q <= 1'b0;
          c_q  <= '0;
        end
        else
        begin
          s1_q <= raw[i];
          s2_q <= s1_q;
          fp_q <= f_q;
          if (s2_q == f_q)
            c_q <= '0;
          else if (c_q >= lim - FILT_W'(1))
          begin
            f_q <= s2_q;
            c_q <= '0;
          end
          else
            c_q <= c_q + FILT_W'(1);
        end
      end
      assign filt[i]   = f_q;
      assign edge_w[i] = f_q & ~fp_q;
    end
  endgenerate

  wire rst1 = filt[1];
  wire rst2 = filt[0];
  // dual and twin count both channels upward only
  wire inc1 = edge_w[3] & started_q & ~rst1;
  wire inc2 = edge_w[2] & started_q & ~rst2 & (cfg == CFG_DUAL || cfg == CFG_TWIN);
  wire complete = (cfg == CFG_BATCH) && started_q && (sv1 != '0) && (pv1_q >= sv1);

  function automatic logic [VW-1:0] wrap_inc(input logic [VW-1:0] v);
    return (v >= FULL_SCALE) ? '0 : v + VW'(1);
  endfunction : wrap_inc

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pv1_q   <= '0;
      pv2_q   <= '0;
      batch_q <= '0;
      bout_q  <= 1'b0;
    end
    else
    begin
      if (clear || rst1 || complete)
        pv1_q <= '0;
      else if (inc1)
        pv1_q <= wrap_inc(pv1_q);
      if (clear || rst2)
        pv2_q <= '0;
      else if (inc2)
        pv2_q <= wrap_inc(pv2_q);
      if (clear || (cfg == CFG_BATCH && rst2))
        batch_q <= '0;
      else if (complete)
        batch_q <= wrap_inc(batch_q);
      if (clear || (cfg == CFG_BATCH && rst2))
        bout_q <= 1'b0;
      else if (cfg == CFG_BATCH && bsv != '0 && batch_q >= bsv)
        bout_q <= 1'b1;
    end
  end

  // stage one threshold; forecast is a deviation below set value two
  wire [VW-1:0]  fc_thr  = (fcv >= sv2) ? '0 : sv2 - fcv;
  wire [VW-1:0]  thr1    = fcsel ? fc_thr : sv1;
  wire           stage1  = started_q && pv1_q >= thr1;
  wire           stage2  = started_q && pv1_q >= sv2;
  wire signed [VW:0] dual = dsub ? $signed({1'b0, pv1_q}) - $signed({1'b0, pv2_q})
                                 : $signed({1'b0, pv1_q}) + $signed({1'b0, pv2_q});
  wire           dual_hit = started_q && dual >= $signed({1'b0, sv1});

  always_comb
  begin
    control_output_one_d = 1'b0;
    control_output_two_d = 1'b0;
    case (cfg)
      CFG_SINGLE:
      begin
        control_output_one_d = started_q && pv1_q >= sv1;
        control_output_two_d = control_output_one_d;
      end
      CFG_TWO_STAGE:
      begin
        control_output_one_d = swap ? stage2 : stage1;
        control_output_two_d = swap ? stage1 : stage2;
      end
      CFG_BATCH:
      begin
        control_output_one_d = bout_q;
        control_output_two_d = complete;
      end
      CFG_DUAL:
      begin
        control_output_one_d = dual_hit;
        control_output_two_d = dual_hit;
      end
      CFG_TWIN:
      begin
        control_output_one_d = started_q && pv1_q >= sv1;
        control_output_two_d = started_q && pv2_q >= sv2;
      end
      default:
      begin
        control_output_one_d = 1'b0;
        control_output_two_d = 1'b0;
      end
    endcase
  end

  assign act_d  = {control_output_two_d, control_output_one_d};
  assign act_qv = {control_output_two_q, control_output_one_q};

  // activation counters keep thousands directly so the monitor needs no divider
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_act
      logic [9:0]    s_q;
      logic [VW-1:0] m_q;
      wire           rise = act_d[k] & ~act_qv[k] & ~clear;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s_q <= '0;
          m_q <= '0;
        end
        else if (rise)
        begin
          s_q <= (s_q == ACT_UNIT_M1) ? '0 : s_q + 10'(1);
          if (s_q == ACT_UNIT_M1)
            m_q <= m_q + VW'(1);
        end
      end
      assign sub[k]     = s_q;
      assign mon[k]     = m_q;
      assign alarm_w[k] = (thr[k] != '0) &&
                          (m_q > thr[k] || (m_q == thr[k] && s_q != '0));
    end
  endgenerate

  // twin watches either output; otherwise output two (mirrors one on 1-stage)
  wire mon_st = (cfg == CFG_TWIN) ? (control_output_one_q | control_output_two_q) : control_output_two_q;
  always_comb
  begin
    case (csel)
      SEL_RED:    colour_d = COL_RED;
      SEL_GREEN:  colour_d = COL_GREEN;
      SEL_ORANGE: colour_d = COL_ORANGE;
      SEL_R_G:    colour_d = mon_st ? COL_GREEN : COL_RED;
      SEL_G_R:    colour_d = mon_st ? COL_RED : COL_GREEN;
      SEL_R_O:    colour_d = mon_st ? COL_ORANGE : COL_RED;
      SEL_O_R:    colour_d = mon_st ? COL_RED : COL_ORANGE;
      SEL_G_O:    colour_d = mon_st ? COL_ORANGE : COL_GREEN;
      SEL_O_G:    colour_d = mon_st ? COL_GREEN : COL_ORANGE;
      default:    colour_d = COL_RED;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control_output_one_q <= 1'b0;
      control_output_two_q <= 1'b0;
      pan_q  <= '0;
    end
    else
    begin
      control_output_one_q <= control_output_one_d & ~clear;
      control_output_two_q <= control_output_two_d & ~clear;
      pan_q  <= '{control_output_one: control_output_one_q, control_output_two: control_output_two_q,
                  colour: colour_d, alarm: |alarm_w};
    end
  end
  assign panel_out = pan_q;

  // monitor registers are read-only: writes to them fall outside wmapped
  always_comb
  begin
    rd_d = 32'h0;
    case (haddr[7:0])
      OFS_CTRL, OFS_SV1, OFS_SV2, OFS_FC, OFS_BSV, OFS_SVLIM, OFS_FCLIM,
      OFS_BLIM, OFS_THR1, OFS_THR2:
        rd_d = shadow_q[haddr[5:2]];
      OFS_RUN:   rd_d = {31'h0, run_q};
      OFS_STAT:  rd_d = {25'h0, alarm_w, pan_q.colour, started_q, control_output_two_q, control_output_one_q};
      OFS_PV1:   rd_d = {12'h0, pv1_q};
      OFS_PV2:   rd_d = {12'h0, pv2_q};
      OFS_BATCH: rd_d = {12'h0, batch_q};
      OFS_DUAL:  rd_d = {{(32-VW-1){dual[VW]}}, dual};
      OFS_MON1:  rd_d = {12'h0, mon[0]};
      OFS_MON2:  rd_d = {12'h0, mon[1]};
      default:   rd_d = 32'h0;
    endcase
  end

  a_colour_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    csel == SEL_GREEN |=> pan_q.colour == COL_GREEN) else $error("fixed colour wrong");
  a_colour_twin: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg == CFG_TWIN && csel == SEL_R_G && (control_output_one_q || control_output_two_q)
    |=> pan_q.colour == COL_GREEN) else $error("twin colour wrong");
  a_forecast_now: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg == CFG_TWO_STAGE && fcsel && !swap && fcv >= sv2 && started_q && !clear
    |=> control_output_one_q) else $error("forecast not immediate");
  a_alloc_swap: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg == CFG_TWO_STAGE && swap && !clear |=> control_output_one_q == $past(stage2))
    else $error("allocation wrong");
  // a lowered limit does not re-clamp a stored value, so only check on entry
  a_sv_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    aw_q && aa_q == OFS_SV1 |=> shadow_q[OFS_SV1[5:2]] <= shadow_q[OFS_SVLIM[5:2]])
    else $error("set value over limit");
  a_fclim_range: assert property (@(posedge hclk) disable iff (!hresetn)
    shadow_q[OFS_FCLIM[5:2]] >= 32'h1 && shadow_q[OFS_FCLIM[5:2]] <= LIM_RST)
    else $error("forecast limit out of range");
  a_batch_inc: assert property (@(posedge hclk) disable iff (!hresetn)
    complete && !clear && !rst2 && batch_q < FULL_SCALE
    |=> batch_q == $past(batch_q) + VW'(1) && pv1_q == '0) else $error("batch step");
  a_dual_out: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg == CFG_DUAL && dual_hit && !clear |=> control_output_one_q && control_output_two_q)
    else $error("dual output missing");
  a_mon_step: assert property (@(posedge hclk) disable iff (!hresetn)
    g_act[0].rise && sub[0] == ACT_UNIT_M1 |=> mon[0] == $past(mon[0]) + VW'(1))
    else $error("monitor step");
  a_alarm_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    (thr[0] != '0 && mon[0] == thr[0] && sub[0] != '0) || (thr[1] != '0 && mon[1] > thr[1])
    |=> pan_q.alarm) else $error("alarm missing");
  a_apply_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> pv1_q == '0 && pv2_q == '0 && !control_output_one_q && !control_output_two_q)
    else $error("apply did not clear");
  a_edge_once: assert property (@(posedge hclk) disable iff (!hresetn)
    edge_w[3] |=> !edge_w[3]) else $error("edge longer than a cycle");
  c_forecast: cover property (@(posedge hclk) cfg == CFG_TWO_STAGE && fcsel && control_output_one_q);
  c_batch_out: cover property (@(posedge hclk) bout_q);
  c_alarm: cover property (@(posedge hclk) pan_q.alarm);
endmodule : preset_counter_compare_logic

// ---- sim/sensor_model.sv ----
`timescale 1ns/1ps
module sensor_model #(
  parameter int HOLD = 8
) (
  input  wire logic           clk,
  input  wire logic           req_one,
  input  wire logic           req_two,
  input  wire logic           rst_one,
  input  wire logic           rst_two,
  output cnt_pkg::sensor_in_s sens,
  output logic                busy
);
  import cnt_pkg::*;
  int ph_one = 0;
  int ph_two = 0;
  // high and low phases each outlast the input filter, so no count is lost
  always_ff @(posedge clk)
  begin
    if (req_one && ph_one == 0)
      ph_one <= 2 * HOLD;
    else if (ph_one > 0)
      ph_one <= ph_one - 1;
    if (req_two && ph_two == 0)
      ph_two <= 2 * HOLD;
    else if (ph_two > 0)
      ph_two <= ph_two - 1;
  end
  assign sens = {ph_one > HOLD, ph_two > HOLD, rst_one, rst_two};
  assign busy = (ph_one > 0) || (ph_two > 0);
endmodule : sensor_model

// ---- sim/test_preset_counter_compare_logic.sv ----
`timescale 1ns/1ps
module test_preset_counter_compare_logic;
  import cnt_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic        req_one, req_two, rst_one, rst_two;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  sensor_in_s  sensor_in;
  panel_out_s  panel_out;
  int          err_count = 0;
  int          n_tests = 0;
  logic [7:0]  lim_ofs [3] = '{OFS_SVLIM, OFS_FCLIM, OFS_BLIM};
  logic [7:0]  val_ofs [3] = '{OFS_SV1, OFS_FC, OFS_BSV};
  colour_e     off_c [9] = '{COL_RED, COL_GREEN, COL_ORANGE, COL_RED, COL_GREEN,
                             COL_RED, COL_ORANGE, COL_GREEN, COL_ORANGE};
  colour_e     on_c [9] = '{COL_RED, COL_GREEN, COL_ORANGE, COL_GREEN, COL_RED,
                            COL_ORANGE, COL_RED, COL_ORANGE, COL_GREEN};

  preset_counter_compare_logic #(.CNT_SLOW(6), .CNT_FAST(4), .RST_SLOW(8), .RST_FAST(5))
  preset_counter_compare_logic_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sensor_in(sensor_in), .panel_out(panel_out));
  sensor_model #(.HOLD(8)) sensor_model_i (.clk(hclk), .req_one(req_one),
    .req_two(req_two), .rst_one(rst_one), .rst_two(rst_two), .sens(sensor_in),
    .busy(busy));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] clampv(input logic [31:0] x, lo, hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction : clampv

  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 64);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 64);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (k >= 64)
    begin
      err_count++;
      conclude();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  // values live in the low 20 bits; the dual value may carry a sign above them
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e & 32'hfffff, r & 32'hfffff);
  endtask : rdc

  task automatic run(input logic [31:0] ctrl);
    wr(OFS_RUN, 32'h0);
    wr(OFS_CTRL, ctrl);
    wr(OFS_RUN, 32'h1);
    repeat (4) @(posedge hclk);
  endtask : run

  task automatic pulse(input logic two);
    int k;
    if (two)
      req_two <= 1'b1;
    else
      req_one <= 1'b1;
    repeat (2) @(posedge hclk);
    req_one <= 1'b0;
    req_two <= 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 100)
    begin
      @(posedge hclk);
      k++;
    end
    if (k >= 100)
    begin
      err_count++;
      conclude();
    end
    repeat (4) @(posedge hclk);
  endtask : pulse

  task automatic rst(input logic two);
    if (two)
      rst_two <= 1'b1;
    else
      rst_one <= 1'b1;
    repeat (12) @(posedge hclk);
    rst_one <= 1'b0;
    rst_two <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask : rst

  task automatic outs(input logic e1, input logic e2);
    chk("control_output_one", {31'h0, e1}, {31'h0, panel_out.control_output_one});
    chk("control_output_two", {31'h0, e2}, {31'h0, panel_out.control_output_two});
  endtask : outs

  task automatic colour(input colour_e e);
    chk("colour", 32'(e), 32'(panel_out.colour));
  endtask : colour

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial
  begin
    logic [31:0] v, l, el;
    int          a, b, e;
    seed = 32'h304c;
    {hresetn, hsel, hwrite, req_one, req_two, rst_one, rst_two} = 7'h0;
    {haddr, hwdata, htrans, hsize} = 69'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctrl", OFS_CTRL, CTRL_RST);
    rdc("sv1", OFS_SV1, SV_RST);
    rdc("unmapped", 8'h48, 32'h0);
    wr(OFS_MON1, 32'h5);
    rdc("mon1", OFS_MON1, 32'h0);
    wr(OFS_THR1, 32'h4e20);
    rdc("thr1", OFS_THR1, {12'h0, ALARM_MAX});
    for (int i = 0; i < 3; i++)
      rdc("limit reset", lim_ofs[i], LIM_RST);
    for (int i = 0; i < 12; i++)
    begin
      l = (i < 3) ? 32'h0 : (rnd() & 32'hfffff);
      v = rnd() & 32'hfffff;
      el = clampv(l, 32'h1, {12'h0, FULL_SCALE});
      wr(lim_ofs[i % 3], l);
      rdc("limit", lim_ofs[i % 3], el);
      wr(val_ofs[i % 3], v);
      rdc("clamped", val_ofs[i % 3], clampv(v, 32'h0, el));
    end
    for (int i = 0; i < 3; i++)
      wr(lim_ofs[i], {12'h0, FULL_SCALE});
    wr(OFS_SV1, 32'h1);
    wr(OFS_SV2, 32'h1);
    for (int s = 0; s < 9; s++)
    begin
      run({20'h0, s[3:0], 8'h0} | (rnd() & 32'hc0));
      colour(off_c[s]);
      outs(1'b0, 1'b0);
      pulse(1'b0);
      outs(1'b1, 1'b1);
      colour(on_c[s]);
    end
    wr(OFS_SV1, 32'h3);
    wr(OFS_SV2, 32'h3);
    run(32'h0);
    repeat (2) pulse(1'b0);
    rdc("pv1", OFS_PV1, 32'h2);
    wr(OFS_SV1, 32'h1);
    wr(OFS_SV2, 32'h1);
    repeat (8) @(posedge hclk);
    outs(1'b0, 1'b0);
    rdc("pv1 held", OFS_PV1, 32'h2);
    run(32'h0);
    rdc("pv1 cleared", OFS_PV1, 32'h0);
    wr(OFS_SV2, 32'h6);
    wr(OFS_FC, 32'h2);
    run(32'h9);
    for (int k = 1; k <= 6; k++)
    begin
      pulse(1'b0);
      outs(k >= 4, k >= 6);
    end
    wr(OFS_FC, 32'h7);
    run(32'h19);
    outs(1'b0, 1'b1);
    wr(OFS_SV1, 32'h2);
    wr(OFS_BSV, 32'h2);
    run(32'h2);
    for (int k = 1; k <= 4; k++)
    begin
      pulse(1'b0);
      rdc("batch", OFS_BATCH, k / 2);
      chk("batch out", {31'h0, k >= 4}, {31'h0, panel_out.control_output_one});
    end
    rst(1'b1);
    rdc("batch cleared", OFS_BATCH, 32'h0);
    wr(OFS_SV1, 32'h4);
    wr(OFS_SV2, 32'h4);
    for (int m = 0; m < 2; m++)
    begin
      a = int'(rnd() % 3) + 1;
      b = int'(rnd() % 3) + 1;
      run(m ? 32'h23 : 32'h3);
      repeat (a) pulse(1'b0);
      repeat (b) pulse(1'b1);
      e = m ? a - b : a + b;
      rdc("dual", OFS_DUAL, e);
      outs(e >= 4, e >= 4);
    end
    wr(OFS_SV1, 32'h1);
    wr(OFS_SV2, 32'h9);
    run(32'h304);
    pulse(1'b0);
    outs(1'b1, 1'b0);
    colour(COL_GREEN);
    // activation counts only clear on reset, so the alarm run starts from zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("sv2 reset", OFS_SV2, SV_RST);
    wr(OFS_THR1, 32'h1);
    wr(OFS_THR2, 32'h0);
    wr(OFS_SV1, 32'h1);
    wr(OFS_SV2, 32'h1);
    run(32'h0);
    for (int n = 1; n <= 1001; n++)
    begin
      pulse(1'b0);
      rst(1'b0);
      if (n == 1000)
      begin
        rdc("mon1", OFS_MON1, 32'h1);
        chk("alarm", 32'h0, {31'h0, panel_out.alarm});
      end
    end
    chk("alarm", 32'h1, {31'h0, panel_out.alarm});
    rdc("mon2", OFS_MON2, 32'h1);
    conclude();
  end
endmodule : test_preset_counter_compare_logic
